// ### port_b_pin_mux.sv
// Function
// - pin7 field 15:14: gpio, sync serial 2 tx data, timer ch2 line b.
// - pin7 timer line becomes external clock d under phase count or psc.
// - pin6 field 13:12: gpio, sync serial 1 rx clock, async 2 clock.
// - pin5 field 11:10: gpio, sync serial 1 rx sync, async 2 rx data.
// - pin4 field 9:8: gpio, sync serial 1 rx data, async 2 tx data.
// - pin3 field 7:6: gpio, sync serial 1 tx clock, timer ch0 line a.
// - pin2 field 5:4: gpio, sync serial 1 tx sync, timer ch0 line b.
// - pin1 field 3:2: gpio, sync serial 1 tx data, timer ch0 line c.
// - pin1 timer line becomes external clock a under phase count or psc.
// - pin0 field 1:0: gpio, reserved, timer ch0 line d, wake-on-lan.
// - pin0 timer line becomes external clock b under phase count or psc.
// - all function fields reset to general io.
// - sixteen-bit read/write direction register, one bit per pin.
// - direction bit matters only while the pin is general io (here it also picks stored or live data read on every pin).
// - general io pin drives when its direction bit is one.
// - power-on reset clears direction; other resets keep it (here every aresetn clears it).
// - sixteen multiplexed pins with a pin data register (here only pins 0-7 have function fields).
// - output pin drives written data; read returns stored value.
// - input pin read returns live level; write only stores.
//
// Implementation choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ns
module port_b_pin_mux (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus write
  input wire logic [pbmux_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [pbmux_pkg::DATA_W-1:0] wdata,
  input wire logic [pbmux_pkg::STRB_W-1:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // register bus read
  input wire logic [pbmux_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [pbmux_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // timer clock source state
  input wire logic timer_phase_ch0,
  input wire logic timer_phase_ch2,
  input wire logic [2:0] timer_prescale_ch0,
  input wire logic [2:0] timer_prescale_ch2,
  // peripheral side
  input wire pbmux_pkg::periph_drive_s periph_drive,
  output pbmux_pkg::pin_to_periph_s to_periph,
  // pads
  input wire logic [pbmux_pkg::PIN_COUNT-1:0] pin_in,
  output logic [pbmux_pkg::PIN_COUNT-1:0] pin_out,
  output logic [pbmux_pkg::PIN_COUNT-1:0] pin_oe_n
);

  localparam int PC = pbmux_pkg::PIN_COUNT;
  localparam int RW = pbmux_pkg::REG_W;
  localparam int AW = pbmux_pkg::ADDR_W;
  localparam int WL = pbmux_pkg::WORD_LSB;

  logic [RW-1:0] func_sel_q;
  logic [RW-1:0] dir_q;
  logic [RW-1:0] data_q;
  logic [PC-1:0] pin_meta_q;
  logic [PC-1:0] pin_sync_q;
  logic [pbmux_pkg::FIELD_W-1:0] sel [pbmux_pkg::LOW_PINS];
  logic [PC-1:0] gpio_en;
  logic [PC-1:0] alt_val;
  logic [PC-1:0] alt_en;
  logic ext_a;
  logic ext_b;
  logic ext_d;
  pbmux_pkg::pin_to_periph_s to_periph_d;
  logic awready_q;
  logic wready_q;
  logic aw_held_q;
  logic w_held_q;
  logic [AW-1:0] aw_addr_q;
  logic [pbmux_pkg::DATA_W-1:0] w_data_q;
  logic [pbmux_pkg::STRB_W-1:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [pbmux_pkg::DATA_W-1:0] rdata_q;
  logic wr_go;
  logic wr_func;
  logic wr_dir;
  logic wr_data;
  logic [RW-1:0] rd_pins;
  logic [RW-1:0] rd_val;
  logic rd_hit;

  // byte-lane merge of a write into a 16-bit register
  function automatic logic [RW-1:0] merge_bytes(
    input logic [RW-1:0] old_v,
    input logic [pbmux_pkg::DATA_W-1:0] new_v,
    input logic [pbmux_pkg::STRB_W-1:0] strb
  );
    logic [RW-1:0] res;
    res = old_v;
    for (int b = 0; b < pbmux_pkg::REG_BYTES; b++) begin
      if (strb[b]) begin
        res[b*pbmux_pkg::BYTE_W +: pbmux_pkg::BYTE_W] =
          new_v[b*pbmux_pkg::BYTE_W +: pbmux_pkg::BYTE_W];
      end
    end
    return res;
  endfunction

  // bus outputs straight from their flops
  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rresp = rresp_q;
  assign rdata = rdata_q;

  // two-flop synchroniser for the pad levels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
    end else begin
      pin_meta_q <= pin_in;
      pin_sync_q <= pin_meta_q;
    end
  end

  // split the function register into per-pin fields
  for (genvar i = 0; i < pbmux_pkg::LOW_PINS; i++) begin : g_field
    assign sel[i] = func_sel_q[i*pbmux_pkg::FIELD_W +: pbmux_pkg::FIELD_W];
  end

  // timer external clock claims on the timer lines
  assign ext_a = timer_phase_ch0 ||
    (timer_prescale_ch0 == pbmux_pkg::PSC_EXT_A);
  assign ext_b = timer_phase_ch0 ||
    (timer_prescale_ch0 == pbmux_pkg::PSC_EXT_B);
  assign ext_d = timer_phase_ch2 ||
    (timer_prescale_ch2 == pbmux_pkg::PSC_EXT_D);

  // drive selection per pin; high half stays general io
  always_comb begin
    gpio_en = '1;
    alt_val = '0;
    alt_en = '0;
    for (int p = 0; p < pbmux_pkg::LOW_PINS; p++) begin
      gpio_en[p] = (sel[p] == pbmux_pkg::SEL_GPIO);
    end
    case (sel[pbmux_pkg::PIN7])
      pbmux_pkg::SEL_ALT1: begin
        alt_val[pbmux_pkg::PIN7] = periph_drive.sync_serial2_tx_data;
        alt_en[pbmux_pkg::PIN7] = 1'b1;
      end
      pbmux_pkg::SEL_ALT2: begin
        alt_val[pbmux_pkg::PIN7] = periph_drive.timer_ch2_line_b;
        alt_en[pbmux_pkg::PIN7] = periph_drive.timer_ch2_line_b_oe && !ext_d;
      end
      default: ;
    endcase
    case (sel[pbmux_pkg::PIN6])
      pbmux_pkg::SEL_ALT2: begin
        alt_val[pbmux_pkg::PIN6] = periph_drive.async_serial2_clock;
        alt_en[pbmux_pkg::PIN6] = periph_drive.async_serial2_clock_oe;
      end
      default: ;
    endcase
    case (sel[pbmux_pkg::PIN4])
      pbmux_pkg::SEL_ALT2: begin
        alt_val[pbmux_pkg::PIN4] = periph_drive.async_serial2_tx_data;
        alt_en[pbmux_pkg::PIN4] = 1'b1;
      end
      default: ;
    endcase
    case (sel[pbmux_pkg::PIN3])
      pbmux_pkg::SEL_ALT2: begin
        alt_val[pbmux_pkg::PIN3] = periph_drive.timer_ch0_line_a;
        alt_en[pbmux_pkg::PIN3] = periph_drive.timer_ch0_line_a_oe;
      end
      default: ;
    endcase
    case (sel[pbmux_pkg::PIN2])
      pbmux_pkg::SEL_ALT1: begin
        alt_val[pbmux_pkg::PIN2] = periph_drive.sync_serial1_tx_sync;
        alt_en[pbmux_pkg::PIN2] = periph_drive.sync_serial1_tx_sync_oe;
      end
      pbmux_pkg::SEL_ALT2: begin
        alt_val[pbmux_pkg::PIN2] = periph_drive.timer_ch0_line_b;
        alt_en[pbmux_pkg::PIN2] = periph_drive.timer_ch0_line_b_oe;
      end
      default: ;
    endcase
    case (sel[pbmux_pkg::PIN1])
      pbmux_pkg::SEL_ALT1: begin
        alt_val[pbmux_pkg::PIN1] = periph_drive.sync_serial1_tx_data;
        alt_en[pbmux_pkg::PIN1] = 1'b1;
      end
      pbmux_pkg::SEL_ALT2: begin
        alt_val[pbmux_pkg::PIN1] = periph_drive.timer_ch0_line_c;
        alt_en[pbmux_pkg::PIN1] = periph_drive.timer_ch0_line_c_oe && !ext_a;
      end
      default: ;
    endcase
    case (sel[pbmux_pkg::PIN0])
      pbmux_pkg::SEL_ALT2: begin
        alt_val[pbmux_pkg::PIN0] = periph_drive.timer_ch0_line_d;
        alt_en[pbmux_pkg::PIN0] = periph_drive.timer_ch0_line_d_oe && !ext_b;
      end
      pbmux_pkg::SEL_ALT3: begin
        alt_val[pbmux_pkg::PIN0] = periph_drive.wake_on_lan_output;
        alt_en[pbmux_pkg::PIN0] = 1'b1;
      end
      default: ;
    endcase
  end

  // pin levels toward the peripherals, zero when not routed
  always_comb begin
    to_periph_d = '0;
    if (sel[pbmux_pkg::PIN7] == pbmux_pkg::SEL_ALT2) begin
      to_periph_d.timer_ext_clock_d = ext_d && pin_sync_q[pbmux_pkg::PIN7];
      to_periph_d.timer_ch2_line_b = !ext_d && pin_sync_q[pbmux_pkg::PIN7];
    end
    if (sel[pbmux_pkg::PIN6] == pbmux_pkg::SEL_ALT1) begin
      to_periph_d.sync_serial1_rx_clock = pin_sync_q[pbmux_pkg::PIN6];
    end
    if (sel[pbmux_pkg::PIN6] == pbmux_pkg::SEL_ALT2) begin
      to_periph_d.async_serial2_clock = pin_sync_q[pbmux_pkg::PIN6];
    end
    if (sel[pbmux_pkg::PIN5] == pbmux_pkg::SEL_ALT1) begin
      to_periph_d.sync_serial1_rx_sync = pin_sync_q[pbmux_pkg::PIN5];
    end
    if (sel[pbmux_pkg::PIN5] == pbmux_pkg::SEL_ALT2) begin
      to_periph_d.async_serial2_rx_data = pin_sync_q[pbmux_pkg::PIN5];
    end
    if (sel[pbmux_pkg::PIN4] == pbmux_pkg::SEL_ALT1) begin
      to_periph_d.sync_serial1_rx_data = pin_sync_q[pbmux_pkg::PIN4];
    end
    if (sel[pbmux_pkg::PIN3] == pbmux_pkg::SEL_ALT1) begin
      to_periph_d.sync_serial1_tx_clock = pin_sync_q[pbmux_pkg::PIN3];
    end
    if (sel[pbmux_pkg::PIN3] == pbmux_pkg::SEL_ALT2) begin
      to_periph_d.timer_ch0_line_a = pin_sync_q[pbmux_pkg::PIN3];
    end
    if (sel[pbmux_pkg::PIN2] == pbmux_pkg::SEL_ALT1) begin
      to_periph_d.sync_serial1_tx_sync = pin_sync_q[pbmux_pkg::PIN2];
    end
    if (sel[pbmux_pkg::PIN2] == pbmux_pkg::SEL_ALT2) begin
      to_periph_d.timer_ch0_line_b = pin_sync_q[pbmux_pkg::PIN2];
    end
    if (sel[pbmux_pkg::PIN1] == pbmux_pkg::SEL_ALT2) begin
      to_periph_d.timer_ext_clock_a = ext_a && pin_sync_q[pbmux_pkg::PIN1];
      to_periph_d.timer_ch0_line_c = !ext_a && pin_sync_q[pbmux_pkg::PIN1];
    end
    if (sel[pbmux_pkg::PIN0] == pbmux_pkg::SEL_ALT2) begin
      to_periph_d.timer_ext_clock_b = ext_b && pin_sync_q[pbmux_pkg::PIN0];
      to_periph_d.timer_ch0_line_d = !ext_b && pin_sync_q[pbmux_pkg::PIN0];
    end
  end

  // registered peripheral inputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      to_periph <= '0;
    end else begin
      to_periph <= to_periph_d;
    end
  end

  // one pad driver per port pin
  for (genvar i = 0; i < PC; i++) begin : g_pin
    pin_drive_cell u_cell (
      .aclk(aclk),
      .aresetn(aresetn),
      .gpio_en(gpio_en[i]),
      .dir(dir_q[i]),
      .data(data_q[i]),
      .alt_val(alt_val[i]),
      .alt_en(alt_en[i]),
      .pin_out(pin_out[i]),
      .pin_oe_n(pin_oe_n[i])
    );
  end

  // write address channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      aw_held_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (awvalid && awready_q) begin
      awready_q <= 1'b0;
      aw_held_q <= 1'b1;
      aw_addr_q <= awaddr;
    end else if (wr_go) begin
      aw_held_q <= 1'b0;
    end else if (!aw_held_q && !bvalid_q) begin
      awready_q <= 1'b1;
    end
  end

  // write data channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_q <= 1'b0;
      w_held_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else if (wvalid && wready_q) begin
      wready_q <= 1'b0;
      w_held_q <= 1'b1;
      w_data_q <= wdata;
      w_strb_q <= wstrb;
    end else if (wr_go) begin
      w_held_q <= 1'b0;
    end else if (!w_held_q && !bvalid_q) begin
      wready_q <= 1'b1;
    end
  end

  // write decode once both halves are held
  assign wr_go = aw_held_q && w_held_q && !bvalid_q;
  assign wr_func = wr_go &&
    (aw_addr_q[AW-1:WL] == pbmux_pkg::ADDR_FUNC[AW-1:WL]);
  assign wr_dir = wr_go &&
    (aw_addr_q[AW-1:WL] == pbmux_pkg::ADDR_DIR[AW-1:WL]);
  assign wr_data = wr_go &&
    (aw_addr_q[AW-1:WL] == pbmux_pkg::ADDR_DATA[AW-1:WL]);

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= pbmux_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q <= (wr_func || wr_dir || wr_data) ?
        pbmux_pkg::RESP_OKAY : pbmux_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // function select register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      func_sel_q <= pbmux_pkg::FUNC_RST;
    end else if (wr_func) begin
      func_sel_q <= merge_bytes(func_sel_q, w_data_q, w_strb_q);
    end
  end

  // direction register, cleared by every aresetn reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dir_q <= pbmux_pkg::DIR_RST;
    end else if (wr_dir) begin
      dir_q <= merge_bytes(dir_q, w_data_q, w_strb_q);
    end
  end

  // pin data register, stored whatever the direction
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_q <= pbmux_pkg::DATA_RST;
    end else if (wr_data) begin
      data_q <= merge_bytes(data_q, w_data_q, w_strb_q);
    end
  end

  // read value: stored bit for outputs, live level for inputs
  assign rd_pins = (dir_q & data_q) | (~dir_q & pin_sync_q);
  always_comb begin
    rd_hit = 1'b1;
    case (araddr[AW-1:WL])
      pbmux_pkg::ADDR_FUNC[AW-1:WL]: rd_val = func_sel_q;
      pbmux_pkg::ADDR_DIR[AW-1:WL]: rd_val = dir_q;
      pbmux_pkg::ADDR_DATA[AW-1:WL]: rd_val = rd_pins;
      default: begin
        rd_val = '0;
        rd_hit = 1'b0;
      end
    endcase
  end

  // read address acceptance
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
    end else if (arvalid && arready_q) begin
      arready_q <= 1'b0;
    end else if (!rvalid_q) begin
      arready_q <= 1'b1;
    end
  end

  // read data channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= pbmux_pkg::RESP_OKAY;
    end else if (arvalid && arready_q) begin
      rvalid_q <= 1'b1;
      rdata_q <= {{(pbmux_pkg::DATA_W-RW){1'b0}}, rd_val};
      rresp_q <= rd_hit ? pbmux_pkg::RESP_OKAY : pbmux_pkg::RESP_SLVERR;
    end else if (rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_both_held;
    aw_held_q && w_held_q && !bvalid_q;
  endsequence
  sequence s_resp_up;
    bvalid_q && !aw_held_q && !w_held_q;
  endsequence

  a_reset_state_clear: assert property (
    $rose(aresetn) |-> func_sel_q == pbmux_pkg::FUNC_RST && dir_q == '0)
    else $error("registers not cleared by reset");
  a_write_resp_seq: assert property (
    s_both_held |=> s_resp_up)
    else $error("write response did not follow held write");
  a_dir_write_take: assert property (
    wr_dir && w_strb_q == '1 |=> dir_q == $past(w_data_q[RW-1:0]))
    else $error("direction write not stored");
  a_gpio_out_drive: assert property (
    sel[pbmux_pkg::PIN0] == pbmux_pkg::SEL_GPIO && dir_q[0]
    |=> !pin_oe_n[0] && pin_out[0] == $past(data_q[0]))
    else $error("gpio output not driving data");
  a_periph_dir_ignored: assert property (
    sel[pbmux_pkg::PIN3] == pbmux_pkg::SEL_ALT2
    |=> pin_oe_n[3] == !$past(periph_drive.timer_ch0_line_a_oe))
    else $error("peripheral pin follows direction bit");
  a_pin7_ext_clock: assert property (
    sel[pbmux_pkg::PIN7] == pbmux_pkg::SEL_ALT2 && ext_d |=> pin_oe_n[7])
    else $error("pin7 drives while external clock");
  a_pin0_wake_out: assert property (
    sel[pbmux_pkg::PIN0] == pbmux_pkg::SEL_ALT3
    |=> !pin_oe_n[0] && pin_out[0] == $past(periph_drive.wake_on_lan_output))
    else $error("wake output not on pin0");
  a_reserved_code_off: assert property (
    sel[pbmux_pkg::PIN7] == pbmux_pkg::SEL_ALT3 |=> pin_oe_n[7])
    else $error("reserved code drives pin7");
  a_rx_clock_route: assert property (
    sel[pbmux_pkg::PIN6] == pbmux_pkg::SEL_ALT1
    |=> to_periph.sync_serial1_rx_clock == $past(pin_sync_q[6]))
    else $error("pin6 level not routed");
  a_data_read_mix: assert property (
    arvalid && arready_q &&
    araddr[AW-1:WL] == pbmux_pkg::ADDR_DATA[AW-1:WL]
    |=> rvalid_q && rdata_q[0] ==
      ($past(dir_q[0]) ? $past(data_q[0]) : $past(pin_sync_q[0])))
    else $error("data read returned wrong source");

endmodule

// ### pbmux_pkg.sv
package pbmux_pkg;

  // bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int STRB_W = DATA_W / 8;
  localparam int BYTE_W = 8;
  localparam int WORD_LSB = 2;

  // port geometry
  localparam int PIN_COUNT = 16;
  localparam int LOW_PINS = 8;
  localparam int FIELD_W = 2;
  localparam int REG_W = 16;
  localparam int REG_BYTES = REG_W / BYTE_W;

  // register byte addresses
  localparam logic [ADDR_W-1:0] ADDR_FUNC = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_DIR = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_DATA = 8'h08;

  // reset values
  localparam logic [REG_W-1:0] FUNC_RST = 16'h0000;
  localparam logic [REG_W-1:0] DIR_RST = 16'h0000;
  localparam logic [REG_W-1:0] DATA_RST = 16'h0000;

  // pin function codes
  localparam logic [FIELD_W-1:0] SEL_GPIO = 2'h0;
  localparam logic [FIELD_W-1:0] SEL_ALT1 = 2'h1;
  localparam logic [FIELD_W-1:0] SEL_ALT2 = 2'h2;
  localparam logic [FIELD_W-1:0] SEL_ALT3 = 2'h3;

  // pin numbers of the low half
  localparam int PIN0 = 0;
  localparam int PIN1 = 1;
  localparam int PIN2 = 2;
  localparam int PIN3 = 3;
  localparam int PIN4 = 4;
  localparam int PIN5 = 5;
  localparam int PIN6 = 6;
  localparam int PIN7 = 7;

  // timer prescaler codes that pick an external clock
  localparam logic [2:0] PSC_EXT_A = 3'h4;
  localparam logic [2:0] PSC_EXT_B = 3'h5;
  localparam logic [2:0] PSC_EXT_D = 3'h7;

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // drive requests from the peripherals (oe high = wants to drive)
  typedef struct packed {
    logic sync_serial2_tx_data;
    logic timer_ch2_line_b;
    logic timer_ch2_line_b_oe;
    logic async_serial2_clock;
    logic async_serial2_clock_oe;
    logic async_serial2_tx_data;
    logic timer_ch0_line_a;
    logic timer_ch0_line_a_oe;
    logic sync_serial1_tx_sync;
    logic sync_serial1_tx_sync_oe;
    logic timer_ch0_line_b;
    logic timer_ch0_line_b_oe;
    logic sync_serial1_tx_data;
    logic timer_ch0_line_c;
    logic timer_ch0_line_c_oe;
    logic timer_ch0_line_d;
    logic timer_ch0_line_d_oe;
    logic wake_on_lan_output;
  } periph_drive_s;

  // pin levels routed to the peripherals
  typedef struct packed {
    logic timer_ch2_line_b;
    logic timer_ext_clock_d;
    logic sync_serial1_rx_clock;
    logic async_serial2_clock;
    logic sync_serial1_rx_sync;
    logic async_serial2_rx_data;
    logic sync_serial1_rx_data;
    logic sync_serial1_tx_clock;
    logic timer_ch0_line_a;
    logic sync_serial1_tx_sync;
    logic timer_ch0_line_b;
    logic timer_ch0_line_c;
    logic timer_ext_clock_a;
    logic timer_ch0_line_d;
    logic timer_ext_clock_b;
  } pin_to_periph_s;

endpackage

// ### pin_drive_cell.sv
`timescale 1ns/1ns
module pin_drive_cell (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // general io control
  input wire logic gpio_en,
  input wire logic dir,
  input wire logic data,
  // peripheral drive
  input wire logic alt_val,
  input wire logic alt_en,
  // pad side
  output logic pin_out,
  output logic pin_oe_n
);

  // registered pad driver, released after reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_out <= 1'b0;
      pin_oe_n <= 1'b1;
    end else if (gpio_en) begin
      pin_out <= data;
      pin_oe_n <= !dir;
    end else begin
      pin_out <= alt_val;
      pin_oe_n <= !alt_en;
    end
  end

endmodule

// ### pad_model.sv
`timescale 1ns/1ns
module pad_model (
  // block pads
  input wire logic [15:0] pin_out,
  input wire logic [15:0] pin_oe_n,
  // level the outside world holds when the block lets go
  input wire logic [15:0] ext_lvl,
  // resolved wire level
  output logic [15:0] pin_in
);
  // the block's own driver wins over the outside level
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_lvl);
endmodule

// ### port_b_low_pin_function_select_tb_top.sv
`timescale 1ns/1ns
module port_b_low_pin_function_select_tb_top;
  // stimulus
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic timer_phase_ch0 = 1'b0;
  logic timer_phase_ch2 = 1'b0;
  logic [2:0] timer_prescale_ch0 = 3'h0;
  logic [2:0] timer_prescale_ch2 = 3'h0;
  pbmux_pkg::periph_drive_s periph_drive = '0;
  logic [15:0] ext_lvl = 16'h0;
  // design outputs
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] pin_in, pin_out, pin_oe_n;
  pbmux_pkg::pin_to_periph_s to_periph;
  // bookkeeping
  logic [15:0] func_v = 16'h0;
  logic [15:0] dir_v = 16'h0;
  logic [15:0] data_v = 16'h0;
  logic [15:0] wr_v = 16'h0;
  logic [3:0] strb_v = 4'hf;
  logic [33:0] exp_q[$];
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;

  port_b_pin_mux u_port_b_pin_mux (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready,
    .timer_phase_ch0, .timer_phase_ch2, .timer_prescale_ch0,
    .timer_prescale_ch2, .periph_drive, .to_periph, .pin_in, .pin_out,
    .pin_oe_n
  );
  pad_model u_pad_model (.pin_out, .pin_oe_n, .ext_lvl, .pin_in);

  // 250 MHz clock
  always #2 aclk = ~aclk;

  task automatic report_and_stop();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // hang guard
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end

  task automatic chk_bus(input string w, input logic [33:0] e, g);
    checked++;
    if (e !== g) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", w, e, g);
    end
  endtask

  task automatic chk_pin(input string w, input logic [15:0] e, g);
    checked++;
    if (e !== g) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", w, e, g);
    end
  endtask

  // bus answers are matched against the oldest note
  always @(posedge aclk) begin
    if (bvalid && bready)
      chk_bus("bresp", exp_q.pop_front(), {bresp, 32'h0});
    if (rvalid && rready)
      chk_bus("rdata", exp_q.pop_front(), {rresp, rdata});
  end

  task automatic wr(input logic [7:0] a, input logic [15:0] d,
                    input logic [1:0] r);
    @(posedge aclk);
    exp_q.push_back({r, 32'h0});
    awaddr <= a;
    wdata <= {16'($urandom), d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [1:0] r,
                    input logic [15:0] d);
    @(posedge aclk);
    exp_q.push_back({r, 16'h0, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
  endtask

  // expected {oe_n, out} of one pad; out is masked where not driven
  function automatic logic [1:0] exp_pin(input int p);
    logic [1:0] c;
    logic ea, eb, ed;
    pbmux_pkg::periph_drive_s d;
    d = periph_drive;
    c = (p < 8) ? func_v[2*p +: 2] : 2'h0;
    ea = timer_phase_ch0 || timer_prescale_ch0 == pbmux_pkg::PSC_EXT_A;
    eb = timer_phase_ch0 || timer_prescale_ch0 == pbmux_pkg::PSC_EXT_B;
    ed = timer_phase_ch2 || timer_prescale_ch2 == pbmux_pkg::PSC_EXT_D;
    case (p * 4 + c)
      29: return {1'b0, d.sync_serial2_tx_data};
      30: return ed ? 2'h2
        : {~d.timer_ch2_line_b_oe, d.timer_ch2_line_b};
      26: return {~d.async_serial2_clock_oe, d.async_serial2_clock};
      18: return {1'b0, d.async_serial2_tx_data};
      14: return {~d.timer_ch0_line_a_oe, d.timer_ch0_line_a};
      9: return {~d.sync_serial1_tx_sync_oe, d.sync_serial1_tx_sync};
      10: return {~d.timer_ch0_line_b_oe, d.timer_ch0_line_b};
      5: return {1'b0, d.sync_serial1_tx_data};
      6: return ea ? 2'h2
        : {~d.timer_ch0_line_c_oe, d.timer_ch0_line_c};
      2: return eb ? 2'h2
        : {~d.timer_ch0_line_d_oe, d.timer_ch0_line_d};
      3: return {1'b0, d.wake_on_lan_output};
      default: return (c == 2'h0) ? {~dir_v[p], data_v[p]} : 2'h2;
    endcase
  endfunction

  // expected pin levels toward the peripherals under func_v
  function automatic pbmux_pkg::pin_to_periph_s exp_route();
    pbmux_pkg::pin_to_periph_s t;
    logic [7:0] lv;
    logic [1:0] v;
    logic ea, eb, ed;
    ea = timer_phase_ch0 || timer_prescale_ch0 == pbmux_pkg::PSC_EXT_A;
    eb = timer_phase_ch0 || timer_prescale_ch0 == pbmux_pkg::PSC_EXT_B;
    ed = timer_phase_ch2 || timer_prescale_ch2 == pbmux_pkg::PSC_EXT_D;
    for (int i = 0; i < 8; i++) begin
      v = exp_pin(i);
      lv[i] = v[1] ? ext_lvl[i] : v[0];
    end
    t = '0;
    t.timer_ext_clock_d = func_v[15:14] == 2'h2 && ed && lv[7];
    t.timer_ch2_line_b = func_v[15:14] == 2'h2 && !ed && lv[7];
    t.sync_serial1_rx_clock = func_v[13:12] == 2'h1 && lv[6];
    t.async_serial2_clock = func_v[13:12] == 2'h2 && lv[6];
    t.sync_serial1_rx_sync = func_v[11:10] == 2'h1 && lv[5];
    t.async_serial2_rx_data = func_v[11:10] == 2'h2 && lv[5];
    t.sync_serial1_rx_data = func_v[9:8] == 2'h1 && lv[4];
    t.sync_serial1_tx_clock = func_v[7:6] == 2'h1 && lv[3];
    t.timer_ch0_line_a = func_v[7:6] == 2'h2 && lv[3];
    t.sync_serial1_tx_sync = func_v[5:4] == 2'h1 && lv[2];
    t.timer_ch0_line_b = func_v[5:4] == 2'h2 && lv[2];
    t.timer_ext_clock_a = func_v[3:2] == 2'h2 && ea && lv[1];
    t.timer_ch0_line_c = func_v[3:2] == 2'h2 && !ea && lv[1];
    t.timer_ext_clock_b = func_v[1:0] == 2'h2 && eb && lv[0];
    t.timer_ch0_line_d = func_v[1:0] == 2'h2 && !eb && lv[0];
    return t;
  endfunction

  task automatic settle_and_check();
    logic [15:0] en, eo;
    logic [1:0] v;
    repeat (4) @(posedge aclk);
    #1;
    for (int i = 0; i < 16; i++) begin
      v = exp_pin(i);
      en[i] = v[1];
      eo[i] = v[0];
    end
    chk_pin("pin_oe_n", en, pin_oe_n);
    chk_pin("pin_out", eo & ~en, pin_out & ~en);
  endtask

  // main sequence
  initial begin
    void'($urandom(96));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    settle_and_check();
    rd(pbmux_pkg::ADDR_FUNC, pbmux_pkg::RESP_OKAY, 16'h0);
    rd(pbmux_pkg::ADDR_DIR, pbmux_pkg::RESP_OKAY, 16'h0);
    wr(8'h0c, 16'hffff, pbmux_pkg::RESP_SLVERR);
    rd(8'h0c, pbmux_pkg::RESP_SLVERR, 16'h0);
    repeat (4) begin
      @(posedge aclk);
      strb_v = 4'($urandom);
      wr_v = 16'($urandom);
      dir_v = {strb_v[1] ? wr_v[15:8] : dir_v[15:8],
               strb_v[0] ? wr_v[7:0] : dir_v[7:0]};
      data_v = 16'($urandom);
      ext_lvl <= 16'($urandom);
      wstrb <= strb_v;
      wr(pbmux_pkg::ADDR_DIR, wr_v, pbmux_pkg::RESP_OKAY);
      wstrb <= 4'hf;
      wr(pbmux_pkg::ADDR_DATA, data_v, pbmux_pkg::RESP_OKAY);
      rd(pbmux_pkg::ADDR_DIR, pbmux_pkg::RESP_OKAY, dir_v);
      settle_and_check();
      chk_pin("to_periph", 16'h0, {1'b0, to_periph});
      rd(pbmux_pkg::ADDR_DATA, pbmux_pkg::RESP_OKAY,
         (dir_v & data_v) | (~dir_v & ext_lvl));
    end
    dir_v = 16'hffff;
    ext_lvl <= 16'hffff;
    wr(pbmux_pkg::ADDR_DIR, dir_v, pbmux_pkg::RESP_OKAY);
    for (int p = 0; p < 8; p++) begin
      for (int c = 1; c < 7; c++) begin
        @(posedge aclk);
        func_v = 16'((c - 1) % 3 + 1) << (2 * p);
        periph_drive <= pbmux_pkg::periph_drive_s'(18'($urandom));
        timer_phase_ch0 <= c > 3; // pass two: external clocks
        timer_phase_ch2 <= c > 3;
        timer_prescale_ch0 <= 3'($urandom);
        timer_prescale_ch2 <= 3'($urandom);
        wr(pbmux_pkg::ADDR_FUNC, func_v, pbmux_pkg::RESP_OKAY);
        settle_and_check();
        chk_pin("route", {1'b0, exp_route()}, {1'b0, to_periph});
        rd(pbmux_pkg::ADDR_FUNC, pbmux_pkg::RESP_OKAY, func_v);
      end
    end
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(pbmux_pkg::ADDR_DIR, pbmux_pkg::RESP_OKAY, 16'h0);
    rd(pbmux_pkg::ADDR_FUNC, pbmux_pkg::RESP_OKAY, 16'h0);
    @(posedge aclk);
    report_and_stop();
  end
endmodule
